//--- can_xcvr_fault_report_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module can_xcvr_fault_report_bench;
   logic core_clk = 1'h0, arst_n = 1'h0, start = 1'h0, hold_low = 1'h0, oc = 1'h0, ov = 1'h0;
   logic standby_select = 1'h0, silent_select = 1'h0, loopback_select = 1'h0, bus_open = 1'h0, bus_frc = 1'h0;
   logic reg_write = 1'h0, reg_read = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   wire tx_data, rx_data, fault_out, hi_out, hi_oe, lo_out, lo_oe, rx_low_power, irq, bus_rx_dominant;
   wire [31:0] reg_rdata;
   int error_cnt = 0, samples_checked = 0, cycles = 0;
   assign bus_rx_dominant = bus_frc | (~bus_open & hi_oe & hi_out);
   always #20 core_clk = ~core_clk;
   cxf_fault_xcvr #(.DOM_TIMEOUT_CYC(16'h0014)) dut (.core_clk(core_clk), .arst_n(arst_n), .tx_data(tx_data),
      .rx_data(rx_data), .standby_select(standby_select), .silent_select(silent_select),
      .loopback_select(loopback_select), .bus_rx_dominant(bus_rx_dominant), .overcurrent_detect(oc),
      .overvoltage_detect(ov), .fault_out(fault_out), .bus_high_line_out(hi_out), .bus_high_line_oe(hi_oe),
      .bus_low_line_out(lo_out), .bus_low_line_oe(lo_oe), .rx_low_power(rx_low_power), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
   cxf_ctrl_model ctrl (.core_clk(core_clk), .arst_n(arst_n), .start(start), .hold_low(hold_low),
      .tx_data(tx_data));
   task final_report;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 12000) begin
         error_cnt++;
         final_report();
      end
   end
   task wait_c(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task rise(input int n);
      repeat (n) begin
         @(posedge core_clk) start <= 1'h1;
         @(posedge core_clk) start <= 1'h0;
         wait_c(7);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1'h1; end
      @(posedge core_clk) reg_write <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk) begin reg_addr <= a; reg_read <= 1'h1; end
      @(posedge core_clk) reg_read <= 1'h0;
      #1 `CHK(reg_rdata, e)
   endtask
   task pulse_fault(input logic [1:0] k, input logic e);
      @(posedge core_clk) begin oc <= k[0]; ov <= k[1]; end
      @(posedge core_clk) begin oc <= 1'h0; ov <= 1'h0; end
      wait_c(2);
      `CHK(fault_out, e)
   endtask
   task report(input logic [5:0] code);
      for (int i = 0; i < 16; i++) begin
         rise(1);
         `CHK(rx_data, (i < 6) ? code[5 - i] : 1'h1)
         `CHK(fault_out, 1'h1)
      end
      for (int i = 0; i < 10; i++) begin
         rise(1);
         `CHK(fault_out, i < 9)
      end
   endtask
   task t_overcurrent;
      rise(99);
      pulse_fault(2'h1, 1'h0);
      rise(1);
      pulse_fault(2'h1, 1'h1);
      `CHK(hi_oe, 1'h0)
      report(6'h2a);
      pulse_fault(2'h1, 1'h0);
      rise(99);
      pulse_fault(2'h1, 1'h0);
   endtask
   task t_first_fault;
      rise(1);
      pulse_fault(2'h2, 1'h1);
      pulse_fault(2'h1, 1'h1);
      report(6'h2c);
   endtask
   task t_modes;
      rise(100);
      @(posedge core_clk) begin standby_select <= 1'h1; hold_low <= 1'h1; end
      pulse_fault(2'h1, 1'h0);
      @(posedge core_clk) bus_frc <= 1'h1;
      wait_c(10);
      `CHK(rx_data, 1'h1)
      `CHK(rx_low_power, 1'h1)
      `CHK(hi_oe, 1'h0)
      wait_c(20);
      `CHK(rx_data, 1'h0)
      @(posedge core_clk) begin bus_frc <= 1'h0; hold_low <= 1'h0; standby_select <= 1'h0; end
      rise(1);
      `CHK(fault_out, 1'h0)
      @(posedge core_clk) begin silent_select <= 1'h1; bus_frc <= 1'h1; hold_low <= 1'h1; end
      wait_c(3);
      `CHK(rx_data, 1'h0)
      `CHK(hi_oe, 1'h0)
      pulse_fault(2'h1, 1'h0);
      @(posedge core_clk) begin bus_frc <= 1'h0; silent_select <= 1'h0; loopback_select <= 1'h1; end
      wait_c(3);
      `CHK(rx_data, 1'h0)
      `CHK(hi_oe, 1'h0)
      @(posedge core_clk) hold_low <= 1'h0;
      wait_c(2);
      `CHK(rx_data, 1'h1)
      @(posedge core_clk) loopback_select <= 1'h0;
   endtask
   task t_timeout;
      @(posedge core_clk) hold_low <= 1'h1;
      wait_c(3);
      `CHK({hi_oe, hi_out, lo_oe, lo_out, rx_data}, 5'h1c)
      wait_c(22);
      `CHK(hi_oe, 1'h0)
      rise(1);
      `CHK(hi_oe, 1'h1)
      @(posedge core_clk) hold_low <= 1'h0;
   endtask
   task t_tx_failure;
      wr(8'h00, 32'hf);
      wr(8'h04, 32'h1);
      rise(1);
      @(posedge core_clk) bus_open <= 1'h1;
      rise(9);
      `CHK(fault_out, 1'h0)
      rise(1);
      wait_c(1);
      `CHK(fault_out, 1'h1)
      `CHK(irq, 1'h1)
      rd(8'h00, 32'h1);
      wr(8'h00, 32'h1);
      wait_c(2);
      `CHK(irq, 1'h0)
      rd(8'h04, 32'h1);
      rd(8'h08, 32'h0000_06b2);
      rd(8'h40, 32'h0);
      @(posedge core_clk) bus_open <= 1'h0;
      report(6'h32);
      `CHK(irq, 1'h0)
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      arst_n <= 1'h1;
      t_overcurrent();
      t_first_fault();
      t_modes();
      t_timeout();
      t_tx_failure();
      final_report();
   end
endmodule // can_xcvr_fault_report_bench
`default_nettype wire

//--- cxf_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module cxf_ctrl_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic hold_low,
   output logic tx_data
);
   logic [2:0] ph;
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph <= 3'h0;
         tx_data <= 1'h1;
      end else if (ph != 3'h0) begin
         ph <= ph - 3'h1;
         tx_data <= (ph <= 3'h2);
      end else begin
         ph <= start ? 3'h5 : 3'h0;
         tx_data <= ~(start | hold_low);
      end
   end
endmodule // cxf_ctrl_model
`default_nettype wire

//--- cxf_defines.vh
// Contract
// (RULE1) Armed detection flags transmission failure after 10 consecutive mismatching transmit cycles.
// (RULE2) Any fault raises the fault output and releases both bus lines.
// (RULE3) Only the first fault's 6-bit code is held; later faults ignored until cleared.
// (RULE4) Controller gives 16 transmit rising edges; device shifts the code out on receive.
// (RULE5) Fault cannot clear before all six code bits were shifted out.
// (RULE6) Ten further transmit pulses after reporting clear the fault and drop the output.
// (RULE7) After clearing, detection disarms and rearms after 100 more transmit rising edges.
// (RULE8) Standby high turns transmitter off, receiver low power; low returns to normal.
// (RULE9) In standby, dominant bus longer than wake filter time pulls receive output low.
// (RULE10) Fault detection stays inactive while standby is selected.
// (RULE11) Silent high disables transmitter regardless of transmit input; receive follows bus.
// (RULE12) Controller clears any fault before asserting silent select.
// (RULE13) Loopback high holds bus recessive and routes transmit input to receive output.
// (RULE14) Loopback low gives normal mode, bus driven from transmit input.
// (RULE15) After power-up detection arms only after 100 transmit rising edges.
// (RULE16) Codes: overcurrent 101010, overvoltage 101100, transmission failure 110010.
// (RULE17) Detection also inactive in silent mode; faults detected only in normal mode.
// (RULE18) Code goes out MSB first, one bit per rising edge, receive high otherwise.
// (RULE19) Transmit low past dominant timeout releases bus; next rising edge re-enables driver.
`ifndef CXF_DEFINES_VH
`define CXF_DEFINES_VH

`define CXF_CLK_PERIOD_NS 40
`define CXF_WAKE_FILTER_NS 1000
// Wake filter in clock cycles, sized for the 16-bit timer limit
`define CXF_WAKE_FILTER_CYC 16'd25
`define CXF_DOM_TIMEOUT_US 2000
// Dominant timeout in clock cycles, sized for the 16-bit timer limit
`define CXF_DOM_TIMEOUT_CYC 16'd50000

`define CXF_ARM_EDGES 7'd100
`define CXF_MISMATCH_LIMIT 4'd10
`define CXF_REPORT_EDGES 5'd16
`define CXF_CLEAR_PULSES 5'd10
`define CXF_CODE_BITS 5'd6

`define CXF_CODE_OVERCURRENT 6'h2a
`define CXF_CODE_OVERVOLTAGE 6'h2c
`define CXF_CODE_TX_FAILURE 6'h32

`define CXF_ADDR_STATUS 8'h00
`define CXF_ADDR_MASK 8'h04
`define CXF_ADDR_INFO 8'h08

`define CXF_EV_FAULT_SET 0
`define CXF_EV_FAULT_CLEAR 1
`define CXF_EV_WAKEUP 2
`define CXF_EV_DOM_TIMEOUT 3
`define CXF_EV_WIDTH 4
`define CXF_MASK_RESET 4'h0

`endif

//--- cxf_fault_xcvr.v
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cxf_defines.vh"
module cxf_fault_xcvr #(
   parameter [15:0] DOM_TIMEOUT_CYC = `CXF_DOM_TIMEOUT_CYC
) (
   input wire core_clk,
   input wire arst_n,
   input wire tx_data,
   output reg rx_data,
   input wire standby_select,
   input wire silent_select,
   input wire loopback_select,
   input wire bus_rx_dominant,
   input wire overcurrent_detect,
   input wire overvoltage_detect,
   output reg fault_out,
   output reg bus_high_line_out,
   output reg bus_high_line_oe,
   output reg bus_low_line_out,
   output reg bus_low_line_oe,
   output reg rx_low_power,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   output reg irq
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_REPORT = 3'b010;
   localparam [2:0] ST_CLEAR = 3'b100;

   reg tx_prev;
   reg [2:0] state;
   reg [6:0] arm_count;
   reg armed;
   reg [3:0] mismatch_count;
   reg [5:0] fault_code;
   reg [4:0] edge_count;
   reg dom_lock;
   reg [`CXF_EV_WIDTH-1:0] status;
   reg [`CXF_EV_WIDTH-1:0] mask;
   reg [`CXF_EV_WIDTH-1:0] events;
   reg next_rx;
   reg next_drive;
   reg [5:0] next_code;
   reg new_fault;

   wire tx_rise = tx_data & ~tx_prev;
   wire normal_mode = ~standby_select & ~silent_select & ~loopback_select;
   wire bus_rx_bit = ~bus_rx_dominant;
   wire dom_expired;
   wire wake_seen;

   // Code bit for an edge index, MSB first, high beyond the code
   function code_bit;
      input [5:0] code;
      input [4:0] idx;
      begin
         if (idx < `CXF_CODE_BITS)
            code_bit = code[3'd5 - idx[2:0]];
         else
            code_bit = 1'b1;
      end
   endfunction

   cxf_level_timer #(.WIDTH(16), .COUNT(DOM_TIMEOUT_CYC)) u_dom_timer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .level(~tx_data & ~dom_lock),
      .expired(dom_expired)
   );

   cxf_level_timer #(.WIDTH(16), .COUNT(`CXF_WAKE_FILTER_CYC)) u_wake_timer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .level(standby_select & bus_rx_dominant),
      .expired(wake_seen)
   );

   // (RULE16) Fault code selection
   always @* begin
      new_fault = 1'b0;
      next_code = fault_code;
      if (overcurrent_detect) begin
         new_fault = 1'b1;
         next_code = `CXF_CODE_OVERCURRENT;
      end else if (overvoltage_detect) begin
         new_fault = 1'b1;
         next_code = `CXF_CODE_OVERVOLTAGE;
      end else if (tx_rise && bus_rx_bit != tx_prev && mismatch_count == `CXF_MISMATCH_LIMIT - 4'd1) begin
         // (RULE1) Tenth mismatching cycle
         new_fault = 1'b1;
         next_code = `CXF_CODE_TX_FAILURE;
      end
      // (RULE10) (RULE17) Normal mode and armed only
      if (!(armed && normal_mode && state == ST_IDLE))
         new_fault = 1'b0;
   end

   // Fault detect, report and clear sequence
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_prev <= 1'b1;
         state <= ST_IDLE;
         arm_count <= 7'd0;
         armed <= 1'b0;
         mismatch_count <= 4'd0;
         fault_code <= 6'h00;
         edge_count <= 5'd0;
         dom_lock <= 1'b0;
         fault_out <= 1'b0;
      end else begin
         tx_prev <= tx_data;
         // (RULE19) Dominant timeout lock until next rising edge
         if (tx_rise)
            dom_lock <= 1'b0;
         else if (dom_expired)
            dom_lock <= 1'b1;
         case (state)
            ST_IDLE: begin
               // (RULE15) (RULE7) Arm after counted edges
               if (tx_rise && !armed) begin
                  if (arm_count == `CXF_ARM_EDGES - 7'd1)
                     armed <= 1'b1;
                  arm_count <= arm_count + 7'd1;
               end
               if (!armed || !normal_mode)
                  mismatch_count <= 4'd0;
               else if (tx_rise)
                  mismatch_count <= (bus_rx_bit != tx_prev) ? mismatch_count + 4'd1 : 4'd0;
               // (RULE2) (RULE3) Latch first fault, raise output
               if (new_fault) begin
                  fault_code <= next_code;
                  fault_out <= 1'b1;
                  edge_count <= 5'd0;
                  mismatch_count <= 4'd0;
                  state <= ST_REPORT;
               end
            end
            ST_REPORT: begin
               // (RULE4) (RULE5) Sixteen edges before clear phase
               if (tx_rise) begin
                  if (edge_count == `CXF_REPORT_EDGES - 5'd1) begin
                     edge_count <= 5'd0;
                     state <= ST_CLEAR;
                  end else begin
                     edge_count <= edge_count + 5'd1;
                  end
               end
            end
            ST_CLEAR: begin
               // (RULE6) (RULE7) Clear fault and disarm
               if (tx_rise) begin
                  if (edge_count == `CXF_CLEAR_PULSES - 5'd1) begin
                     edge_count <= 5'd0;
                     fault_out <= 1'b0;
                     armed <= 1'b0;
                     arm_count <= 7'd0;
                     state <= ST_IDLE;
                  end else begin
                     edge_count <= edge_count + 5'd1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Receive output and bus driver selection
   always @* begin
      next_rx = rx_data;
      next_drive = 1'b0;
      if (state != ST_IDLE) begin
         // (RULE18) Shift code on rising edges
         if (state == ST_REPORT && tx_rise)
            next_rx = code_bit(fault_code, edge_count);
         else if (state == ST_CLEAR)
            next_rx = 1'b1;
      end else if (standby_select) begin
         // (RULE9) Wakeup pulls receive low
         next_rx = ~wake_seen;
      end else if (loopback_select) begin
         // (RULE13) Transmit looped to receive
         next_rx = tx_data;
      end else begin
         // (RULE11) Receive follows bus
         next_rx = bus_rx_bit;
         // (RULE14) (RULE8) Drive only in normal mode
         next_drive = normal_mode & ~tx_data & ~dom_lock & ~dom_expired;
      end
   end

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_data <= 1'b1;
         bus_high_line_out <= 1'b0;
         bus_high_line_oe <= 1'b0;
         bus_low_line_out <= 1'b0;
         bus_low_line_oe <= 1'b0;
         rx_low_power <= 1'b0;
      end else begin
         rx_data <= next_rx;
         // (RULE2) Driver off, lines released during fault
         bus_high_line_out <= next_drive & ~new_fault;
         bus_high_line_oe <= next_drive & ~new_fault;
         bus_low_line_out <= 1'b0;
         bus_low_line_oe <= next_drive & ~new_fault;
         // (RULE8) Low-power receiver in standby
         rx_low_power <= standby_select;
      end
   end

   // Event sources for sticky status
   always @* begin
      events = {`CXF_EV_WIDTH{1'b0}};
      events[`CXF_EV_FAULT_SET] = new_fault;
      events[`CXF_EV_FAULT_CLEAR] = (state == ST_CLEAR) && tx_rise && (edge_count == `CXF_CLEAR_PULSES - 5'd1);
      events[`CXF_EV_WAKEUP] = wake_seen & rx_data;
      events[`CXF_EV_DOM_TIMEOUT] = dom_expired & ~dom_lock;
   end

   // Register port, status write-one-to-clear with set winning
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= {`CXF_EV_WIDTH{1'b0}};
         mask <= `CXF_MASK_RESET;
         reg_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         if (reg_write && reg_addr == `CXF_ADDR_STATUS)
            status <= (status & ~reg_wdata[`CXF_EV_WIDTH-1:0]) | events;
         else
            status <= status | events;
         if (reg_write && reg_addr == `CXF_ADDR_MASK)
            mask <= reg_wdata[`CXF_EV_WIDTH-1:0];
         irq <= |(status & mask);
         reg_rdata <= 32'h0000_0000;
         if (reg_read) begin
            if (reg_addr == `CXF_ADDR_STATUS)
               reg_rdata <= {28'h0000000, status};
            else if (reg_addr == `CXF_ADDR_MASK)
               reg_rdata <= {28'h0000000, mask};
            else if (reg_addr == `CXF_ADDR_INFO)
               reg_rdata <= {13'h0000, edge_count, 2'h0, dom_lock, fault_out, armed, state, fault_code};
            else
               reg_rdata <= 32'h0000_0000;
         end
      end
   end
endmodule // cxf_fault_xcvr
`default_nettype wire

//--- cxf_fault_xcvr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cxf_fault_xcvr_assertions (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic tx_data,
   input wire logic rx_data,
   input wire logic standby_select,
   input wire logic silent_select,
   input wire logic loopback_select,
   input wire logic bus_rx_dominant,
   input wire logic fault_out,
   input wire logic bus_high_line_out,
   input wire logic bus_high_line_oe,
   input wire logic bus_low_line_out,
   input wire logic bus_low_line_oe,
   input wire logic rx_low_power
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   chk_fault_release: assert property (fault_out |-> !bus_high_line_oe && !bus_low_line_oe)
      else $error("bus driven during fault");
   chk_standby_off: assert property ($past(standby_select) |-> !bus_high_line_oe)
      else $error("driver on in standby");
   chk_low_power: assert property (rx_low_power == $past(standby_select))
      else $error("low power flag wrong");
   chk_standby_nofault: assert property ($past(standby_select) |-> !$rose(fault_out))
      else $error("fault raised in standby");
   chk_silent_off: assert property ($past(silent_select) |-> !bus_high_line_oe)
      else $error("driver on in silent mode");
   chk_silent_rx: assert property ($past(silent_select) && !$past(fault_out) |-> rx_data == !$past(bus_rx_dominant))
      else $error("receive not following bus");
   chk_silent_nofault: assert property ($past(silent_select) |-> !$rose(fault_out))
      else $error("fault raised in silent mode");
   chk_loop_quiet: assert property ($past(loopback_select) |-> !bus_high_line_oe)
      else $error("driver on in loopback");
   chk_loop_echo: assert property ($past(loopback_select) && !$past(standby_select) && !$past(fault_out)
      |-> rx_data == $past(tx_data))
      else $error("loopback data wrong");
   chk_driver_cause: assert property (bus_high_line_oe |-> $past(!tx_data) && bus_high_line_out
      && bus_low_line_oe && !bus_low_line_out)
      else $error("driver not from transmit low");
endmodule // cxf_fault_xcvr_assertions
bind cxf_fault_xcvr cxf_fault_xcvr_assertions u_chk (.*);
`default_nettype wire

//--- cxf_level_timer.v
`timescale 1ns/1ps
`default_nettype none
module cxf_level_timer #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] COUNT = {{(WIDTH-1){1'b0}}, 1'b1}
) (
   input wire core_clk,
   input wire arst_n,
   input wire level,
   output reg expired
);
   reg [WIDTH-1:0] count;

   // Counts cycles the level holds; saturates at the limit
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= {WIDTH{1'b0}};
         expired <= 1'b0;
      end else if (!level) begin
         count <= {WIDTH{1'b0}};
         expired <= 1'b0;
      end else if (count >= COUNT) begin
         expired <= 1'b1;
      end else begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule // cxf_level_timer
`default_nettype wire
